// ---- inc/cmd_regs_defs.svh ----
// Offsets, field positions, codes, reset values and timing of the command block
`ifndef CMD_REGS_DEFS_SVH
`define CMD_REGS_DEFS_SVH
// ----------------------------------------------------------------
// Word offsets and address space
// ----------------------------------------------------------------
`define CMD_WADDR       8'h00
`define CTRL_WADDR      8'h24
`define CFG_WADDR       8'h25
`define WORD_COUNT      10'h100
`define BYTES_PER_WORD  10'h003
// ----------------------------------------------------------------
// Command fields and codes
// ----------------------------------------------------------------
`define ACC_F           23:12
`define TOP_F           23:16
`define SUB_F           11:8
`define SEL_F           14:8
`define BUSY_F          23:8
`define LOW12_F         11:0
`define SET_F           7:0
`define ACCESS_CODE     12'hACC
`define SUB_CLEAR0      4'h0
`define SUB_CLEAR1      4'h1
`define SUB_SAVE        4'h2
`define CAL_CODE        8'hCA
`define SOFT_RST_CODE   8'hBD
`define NO_ACTION       8'h00
`define NO_ACTION_HI    16'h0000
`define FREEZE_FREQUENCY_UPDATE_BIT        6
`define LOCK_BIT        5
`define TC_BIT          4
`define TSTOP_BIT       10
// ----------------------------------------------------------------
// Control and configuration fields
// ----------------------------------------------------------------
`define CTL_ACC_BIT     2
`define CTL_CNT_BIT     1
`define CTL_MM_BIT      0
`define REF_F           23:22
`define MULT_FIELDS     10
`define MULT_BIAS       3'h1
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CMD_RST         24'h000000
`define CFG_RST         24'h000000
`define CLK_PERIOD_NS   10
`define FLASH_OP_NS     2000
`define FLASH_OP_CYC    ((`FLASH_OP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- inc/cmd_regs_pkg.sv ----
// Types shared by the command block and its word memory
package cmd_regs_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_FLASH = 2'b01, ST_CAL = 2'b11} op_state_t;
  typedef enum logic [1:0] {REF_SLOT0, REF_SLOT2, REF_DIFF, REF_SUM} zc_ref_t;
  typedef enum logic [1:0] {SRC_MEM, SRC_CMD, SRC_CFG, SRC_ZERO} rd_src_t;
  typedef logic signed [2:0] mult_t;
  typedef mult_t [9:0] mult_vec_t;
  typedef struct packed {
    logic sensor_slot_two;
    logic sensor_slot_zero;
    logic sensor_slot_three;
    logic sensor_slot_one;
    logic chip_temp;
    logic offset_not_gain;
    logic ext_temp_gain_cal_select;
  } cal_sel_t;
  typedef struct packed {
    logic acc_frame_clear;
    logic counter_clear;
    logic minmax_restart;
  } clear_pulses_t;
  typedef struct packed {
    logic freeze_frequency_update;
    logic line_cycle_lock;
    logic temp_gain_compensation;
    logic temp_update_stop;
  } settings_t;
  typedef struct packed {
    op_state_t     op;
    logic [3:0]    flash_sub;
    logic [11:0]   cnt;
    logic [23:0]   cmd;
    logic [23:0]   cfg;
    mult_vec_t     mult;
    settings_t     set;
    logic          nv_valid;
    logic [7:0]    nv_settings;
    logic [23:0]   nv_cfg;
    cal_sel_t      cal_sel;
    logic          cal_start;
    clear_pulses_t clr;
    logic          soft_rst;
    rd_src_t       rd_src;
    logic          rd_pend;
    logic [23:0]   rdata;
    logic          rvalid;
  } st_t;
  typedef struct packed {
    logic        we;
    logic        re;
    logic [7:0]  addr;
    logic [23:0] wdata;
  } mem_req_t;
endpackage : cmd_regs_pkg

// ---- hdl/word_mem.sv ----
// Register-space word memory with registered read data
module word_mem
  import cmd_regs_pkg::*;
(
  // Clock
  input  wire logic        clk_i,
  // Access
  input  wire mem_req_t    req_i,
  output logic      [23:0] rdata_o
);
  logic [23:0] mem_ff [256];
  logic [23:0] rdata_ff;

  always_ff @(posedge clk_i) begin
    if (req_i.we) begin
      mem_ff[req_i.addr] <= req_i.wdata;
    end
    if (req_i.re) begin
      rdata_ff <= mem_ff[req_i.addr];
    end
  end

  assign rdata_o = rdata_ff;
endmodule : word_mem

// ---- hdl/host_command_control_regs.sv ----
// Command, clear-control and input-routing registers with operation sequencing
`include "cmd_regs_defs.svh"
module host_command_control_regs
  import cmd_regs_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rstn_i,
  // Register port
  input  wire logic          addr_is_byte_i,
  input  wire logic [9:0]    reg_addr_i,
  input  wire logic          reg_wr_i,
  input  wire logic [23:0]   reg_wdata_i,
  input  wire logic          reg_rd_i,
  output logic      [23:0]   reg_rdata_o,
  output logic               reg_rvalid_o,
  // Calibration handshake
  output cal_sel_t           cal_select_o,
  output logic               cal_start_o,
  input  wire logic          cal_done_i,
  input  wire cal_sel_t      cal_fail_i,
  // Clear pulses
  output clear_pulses_t      clear_o,
  // Settings and routing
  output settings_t          settings_o,
  output zc_ref_t            zc_ref_o,
  output mult_vec_t          mult_o,
  // Storage and reset status
  output logic               nv_valid_o,
  output logic               soft_reset_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Power-on value models empty storage; rstn_i keeps the storage fields
  st_t         st_ff = '0;
  st_t         nxt_st;
  logic [9:0]  quot;
  logic [9:0]  rem;
  logic [9:0]  widx;
  logic        aok;
  logic [7:0]  waddr;
  logic [23:0] mem_rdata;
  mem_req_t    mem_req;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic mult_vec_t decode_mult(input logic [23:0] c);
    mult_vec_t m;
    m = '0;
    for (int i = 0; i < `MULT_FIELDS; i++) begin
      m[i] = {1'b0, c[2*i +: 2]} - `MULT_BIAS;
    end
    return m;
  endfunction : decode_mult

  function automatic settings_t settings_of(input logic [23:0] c);
    settings_t s;
    s.freeze_frequency_update = c[`FREEZE_FREQUENCY_UPDATE_BIT];
    s.line_cycle_lock         = c[`LOCK_BIT];
    s.temp_gain_compensation  = c[`TC_BIT];
    // Stop bit only has meaning under the no-action code
    s.temp_update_stop = (c[`TOP_F] == `NO_ACTION) && c[`TSTOP_BIT];
    return s;
  endfunction : settings_of

  // Reload used by both pin reset and soft reset; storage survives it
  function automatic st_t boot(input st_t s);
    st_t b;
    b = '0;
    b.op          = ST_IDLE;
    b.nv_valid    = s.nv_valid;
    b.nv_settings = s.nv_settings;
    b.nv_cfg      = s.nv_cfg;
    if (s.nv_valid) begin
      b.cmd = {`NO_ACTION_HI, s.nv_settings};
      b.cfg = s.nv_cfg;
    end else begin
      b.cmd = `CMD_RST;
      b.cfg = `CFG_RST;
    end
    b.mult = decode_mult(b.cfg);
    b.set  = settings_of(b.cmd);
    return b;
  endfunction : boot

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Byte addresses land on multiples of three; others hit nothing
  always_comb begin
    quot  = reg_addr_i / `BYTES_PER_WORD;
    rem   = reg_addr_i % `BYTES_PER_WORD;
    widx  = addr_is_byte_i ? quot : reg_addr_i;
    aok   = (widx < `WORD_COUNT) && (!addr_is_byte_i || rem == 10'h000);
    waddr = widx[7:0];
  end

  // ----------------------------------------------------------------
  // Word memory
  // ----------------------------------------------------------------
  always_comb begin
    mem_req.we    = reg_wr_i && aok;
    mem_req.re    = reg_rd_i && aok;
    mem_req.addr  = waddr;
    mem_req.wdata = reg_wdata_i;
  end

  word_mem u_mem (
    .clk_i   (clk_i),
    .req_i   (mem_req),
    .rdata_o (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.clr       = '0;
    nxt_st.cal_start = 1'b0;
    nxt_st.soft_rst  = 1'b0;

    // Running operations
    case (st_ff.op)
      ST_FLASH: begin
        nxt_st.cnt = st_ff.cnt + 12'h001;
        if (st_ff.cnt == 12'(`FLASH_OP_CYC - 1)) begin
          if (st_ff.flash_sub == `SUB_SAVE) begin
            nxt_st.nv_settings = st_ff.cmd[`SET_F];
            nxt_st.nv_cfg      = st_ff.cfg;
            nxt_st.nv_valid    = 1'b1;
          end else begin
            nxt_st.nv_valid = 1'b0;
          end
          nxt_st.cmd[`BUSY_F] = '0;
          nxt_st.cnt          = '0;
          nxt_st.op           = ST_IDLE;
        end
      end
      ST_CAL: begin
        if (cal_done_i) begin
          nxt_st.cmd[`TOP_F] = `NO_ACTION;
          nxt_st.cmd[`SEL_F] = st_ff.cmd[`SEL_F] & cal_fail_i;
          nxt_st.op          = ST_IDLE;
        end
      end
      default: begin
        nxt_st.op = ST_IDLE;
      end
    endcase

    // Register writes
    if (reg_wr_i && aok) begin
      case (waddr)
        `CMD_WADDR: begin
          // Writes during an operation are dropped so completion is not lost
          if (st_ff.op == ST_IDLE) begin
            nxt_st.cmd = reg_wdata_i;
            if (reg_wdata_i[`ACC_F] == `ACCESS_CODE &&
                (reg_wdata_i[`SUB_F] == `SUB_SAVE ||
                 reg_wdata_i[`SUB_F] == `SUB_CLEAR0 ||
                 reg_wdata_i[`SUB_F] == `SUB_CLEAR1)) begin
              nxt_st.op        = ST_FLASH;
              nxt_st.flash_sub = reg_wdata_i[`SUB_F];
              nxt_st.cnt       = '0;
            end else if (reg_wdata_i[`TOP_F] == `CAL_CODE) begin
              nxt_st.op        = ST_CAL;
              nxt_st.cal_start = 1'b1;
              nxt_st.cal_sel   = reg_wdata_i[`SEL_F];
            end else if (reg_wdata_i[`TOP_F] == `SOFT_RST_CODE &&
                         reg_wdata_i[`LOW12_F] == '0) begin
              nxt_st          = boot(st_ff);
              nxt_st.soft_rst = 1'b1;
            end
          end
        end
        `CTRL_WADDR: begin
          // Self-clearing: each set bit gives one pulse, reserved bits ignored
          nxt_st.clr.acc_frame_clear = reg_wdata_i[`CTL_ACC_BIT];
          nxt_st.clr.counter_clear   = reg_wdata_i[`CTL_CNT_BIT];
          nxt_st.clr.minmax_restart  = reg_wdata_i[`CTL_MM_BIT];
        end
        `CFG_WADDR: begin
          nxt_st.cfg = reg_wdata_i;
        end
        default: begin
        end
      endcase
    end

    // Registered decode so outputs come from flops
    nxt_st.mult = decode_mult(nxt_st.cfg);
    nxt_st.set  = settings_of(nxt_st.cmd);

    // Register reads, two-cycle latency
    nxt_st.rd_pend = reg_rd_i;
    if (!aok) begin
      nxt_st.rd_src = SRC_ZERO;
    end else begin
      case (waddr)
        `CMD_WADDR:  nxt_st.rd_src = SRC_CMD;
        `CTRL_WADDR: nxt_st.rd_src = SRC_ZERO;
        `CFG_WADDR:  nxt_st.rd_src = SRC_CFG;
        default:     nxt_st.rd_src = SRC_MEM;
      endcase
    end
    nxt_st.rvalid = st_ff.rd_pend;
    if (st_ff.rd_pend) begin
      case (st_ff.rd_src)
        SRC_CMD: nxt_st.rdata = st_ff.cmd;
        SRC_CFG: nxt_st.rdata = st_ff.cfg;
        SRC_MEM: nxt_st.rdata = mem_rdata;
        default: nxt_st.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_ff <= boot(st_ff);
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o  = st_ff.rdata;
  assign reg_rvalid_o = st_ff.rvalid;
  assign cal_select_o = st_ff.cal_sel;
  assign cal_start_o  = st_ff.cal_start;
  assign clear_o      = st_ff.clr;
  assign settings_o   = st_ff.set;
  assign zc_ref_o     = zc_ref_t'(st_ff.cfg[`REF_F]);
  assign mult_o       = st_ff.mult;
  assign nv_valid_o   = st_ff.nv_valid;
  assign soft_reset_o = st_ff.soft_rst;

endmodule : host_command_control_regs

// ---- sim/host_command_control_regs_monitor.sv ----
// Assertion checker for the command, control and routing register block
`include "cmd_regs_defs.svh"
module host_command_control_regs_monitor
  import cmd_regs_pkg::*;
(
  // Clock, reset and register port
  input wire logic          clk_i,
  input wire logic          rstn_i,
  input wire logic          addr_is_byte_i,
  input wire logic [9:0]    reg_addr_i,
  input wire logic          reg_wr_i,
  input wire logic [23:0]   reg_wdata_i,
  input wire logic          reg_rd_i,
  input wire logic [23:0]   reg_rdata_o,
  input wire logic          reg_rvalid_o,
  // Datapath side
  input wire cal_sel_t      cal_select_o,
  input wire logic          cal_start_o,
  input wire logic          cal_done_i,
  input wire cal_sel_t      cal_fail_i,
  input wire clear_pulses_t clear_o,
  input wire settings_t     settings_o,
  input wire zc_ref_t       zc_ref_o,
  input wire mult_vec_t     mult_o,
  input wire logic          nv_valid_o,
  input wire logic          soft_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ----------------------------------------------------------------
  // Word-mode write decodes
  // ----------------------------------------------------------------
  wire wcfg = reg_wr_i && !addr_is_byte_i && reg_addr_i == 10'h025;
  wire wctl = reg_wr_i && !addr_is_byte_i && reg_addr_i == 10'h024;

  rd_latency_a: assert property (reg_rd_i |-> ##2 reg_rvalid_o)
    else $error("read answer missing");
  rd_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i, 2))
    else $error("read answer without request");
  unmapped_zero_a: assert property (reg_rd_i && !addr_is_byte_i && reg_addr_i[9:8] != 2'h0
    |-> ##2 reg_rdata_o == 24'h000000) else $error("unmapped read not zero");
  clear_pulse_a: assert property (wctl |=> clear_o == $past(reg_wdata_i[2:0]))
    else $error("clear pulses wrong");
  zc_ref_a: assert property (wcfg |=> zc_ref_o == $past(reg_wdata_i[23:22]))
    else $error("reference select wrong");
  mult_dec_a: assert property (wcfg |=> mult_o[0] == $past(reg_wdata_i[1:0]) + 3'h7
    && mult_o[9] == $past(reg_wdata_i[19:18]) + 3'h7) else $error("multiplier decode wrong");
  cal_start_a: assert property (cal_start_o |-> $past(reg_wr_i)
    && $past(reg_wdata_i[23:16]) == 8'hCA && cal_select_o == $past(reg_wdata_i[14:8]))
    else $error("calibration start without command");
  soft_rst_a: assert property (soft_reset_o |-> $past(reg_wr_i)
    && $past(reg_wdata_i[23:16]) == 8'hBD && $past(reg_wdata_i[11:0]) == 12'h000)
    else $error("soft reset without command");
  cal_cov: cover property (cal_start_o);
  soft_cov: cover property (soft_reset_o);
  save_cov: cover property ($rose(nv_valid_o));
endmodule : host_command_control_regs_monitor

bind host_command_control_regs host_command_control_regs_monitor mon_u (.*);

// ---- sim/cal_datapath_model.sv ----
// Calibration datapath model answering calibration requests
module cal_datapath_model
  import cmd_regs_pkg::*;
#(
  parameter int DELAY = 12
)(
  input  wire logic     clk_i,
  input  wire logic     cal_start_i,
  input  wire cal_sel_t cal_select_i,
  input  wire cal_sel_t fail_pattern_i,
  output logic          cal_done_o,
  output cal_sel_t      cal_fail_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial cal_done_o = 1'b0;
  initial cal_fail_o = '0;
  always @(posedge clk_i) begin
    cal_done_o <= 1'b0;
    // Mask only means something with done, so scramble it otherwise
    cal_fail_o <= ~(cal_select_i & fail_pattern_i);
    if (cal_start_i) begin
      cnt <= DELAY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        cal_done_o <= 1'b1;
        cal_fail_o <= cal_select_i & fail_pattern_i;
      end
    end
  end
endmodule : cal_datapath_model

// ---- sim/host_command_control_regs_tb.sv ----
// Self-checking bench for the command, control and routing register block
`include "cmd_regs_defs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module host_command_control_regs_tb
  import cmd_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk_i = 1'b0, rstn_i = 1'b0, byte_mode = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [9:0]    addr = '0;
  logic [23:0]   wdata = '0, rdata, cfg_a, cfg_b;
  logic          rvalid, cal_start, cal_done, nv_valid, soft_rst;
  cal_sel_t      cal_sel, cal_fail, fail_pat = 7'h2A;
  clear_pulses_t clr;
  settings_t     settings;
  zc_ref_t       zc_ref;
  mult_vec_t     mult;
  logic [23:0]   exp_q[$];
  int            errors = 0, checks_done = 0, cycles = 0, seed = 45, n_soft = 0;

  always #5 clk_i = ~clk_i;
  host_command_control_regs dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .addr_is_byte_i(byte_mode),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .cal_select_o(cal_sel), .cal_start_o(cal_start),
    .cal_done_i(cal_done), .cal_fail_i(cal_fail), .clear_o(clr), .settings_o(settings),
    .zc_ref_o(zc_ref), .mult_o(mult), .nv_valid_o(nv_valid), .soft_reset_o(soft_rst));
  cal_datapath_model cal_u (.clk_i(clk_i), .cal_start_i(cal_start), .cal_select_i(cal_sel),
    .fail_pattern_i(fail_pat), .cal_done_o(cal_done), .cal_fail_o(cal_fail));

  // ----------------------------------------------------------------
  // Bus tasks, scoreboard, watchdog
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic wr_word(input logic [9:0] a, input logic [23:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_word
  task automatic rd_word(input logic [9:0] a, input logic [23:0] e);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : rd_word
  task automatic flash_wait();
    repeat (`FLASH_OP_CYC + 2) @(posedge clk_i);
  endtask : flash_wait
  always @(posedge clk_i) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b0, 1'b1)
      else `CHK(rdata, exp_q.pop_front())
    end
    if (soft_rst === 1'b1) n_soft++;
    cycles++;
    if (cycles == 6000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1 `CHK(nv_valid, 1'b0)
    rd_word(`CMD_WADDR, 24'h000000);
    cfg_a = $random(seed);
    wr_word(`CFG_WADDR, cfg_a);
    @(posedge clk_i) #1;
    `CHK(zc_ref, cfg_a[23:22])
    for (int i = 0; i < 10; i++) `CHK(mult[i], 3'(cfg_a[2*i+:2]) - 3'h1)
    @(posedge clk_i) byte_mode <= 1'b1;
    rd_word(10'h06F, cfg_a);
    rd_word(10'h001, 24'h000000);
    @(posedge clk_i) byte_mode <= 1'b0;
    rd_word(10'h100, 24'h000000);
    // Each clear bit pulses alone; the control word reads back zero
    for (int i = 0; i < 3; i++) begin
      wr_word(`CTRL_WADDR, 24'h000001 << i);
      #1 `CHK(clr, 3'(1 << i))
    end
    rd_word(`CTRL_WADDR, 24'h000000);
    wr_word(`CMD_WADDR, 24'h000470);
    @(posedge clk_i) #1;
    `CHK(settings, 4'hF)
    wr_word(`CMD_WADDR, 24'hACC370);
    @(posedge clk_i) #1;
    `CHK(settings, 4'hE)
    rd_word(`CMD_WADDR, 24'hACC370);
    wr_word(`CMD_WADDR, 24'hCA7F10);
    wr_word(`CMD_WADDR, 24'hBD0000);
    for (int i = 0; i < 100 && cal_done !== 1'b1; i++) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    `CHK(n_soft, 0)
    rd_word(`CMD_WADDR, {9'h000, 7'h7F & fail_pat, 8'h10});
    wr_word(`CMD_WADDR, 24'hACC250);
    flash_wait();
    rd_word(`CMD_WADDR, 24'h000050);
    #1 `CHK(nv_valid, 1'b1)
    cfg_b = $random(seed);
    wr_word(`CFG_WADDR, cfg_b);
    wr_word(`CMD_WADDR, 24'hBD0000);
    repeat (2) @(posedge clk_i);
    `CHK(n_soft, 1)
    rd_word(`CFG_WADDR, cfg_a);
    rd_word(`CMD_WADDR, 24'h000050);
    #1 `CHK(settings, 4'hA)
    // Both erase codes issued as a pair
    wr_word(`CMD_WADDR, 24'hACC020);
    flash_wait();
    wr_word(`CMD_WADDR, 24'hACC120);
    flash_wait();
    rd_word(`CMD_WADDR, 24'h000020);
    #1 `CHK(nv_valid, 1'b0)
    @(posedge clk_i) rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd_word(`CFG_WADDR, 24'h000000);
    rd_word(`CMD_WADDR, 24'h000000);
    repeat (2) @(posedge clk_i);
    `CHK(exp_q.size(), 0)
    finish_test();
  end
endmodule : host_command_control_regs_tb
